// file: src/serial_reg_port.sv
// serial slave port: 32-clock frames, single writes, single and burst reads
// assumes host drives serial clock, select and data from another domain;
// register file and fifos sit on the user side, on the system clock
`timescale 1ns/10ps
module serial_reg_port
  import spi_port_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CHIP_SELECT_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  output logic RD_REQ,
  output spi_port_pkg::addr_t RD_ADDR,
  input wire spi_port_pkg::word_t RD_DATA,
  input wire logic FIFO_VALID,
  output logic ADVANCE,
  output spi_port_pkg::addr_t ADVANCE_ADDR,
  output logic WR_VALID,
  input wire logic WR_READY,
  output spi_port_pkg::addr_t WR_ADDR,
  output spi_port_pkg::word_t WR_DATA
);
  import spi_port_pkg::*;

  localparam int WR_W = ADDR_W + DATA_W;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic mosi_s1;
    logic mosi_s2;
    count_t cnt;
    logic [DATA_W-2:0] shreg;
    addr_t addr;
    logic is_read;
    logic is_burst;
    logic done;
    logic rd_req;
    logic capture;
    logic load_pend;
    word_t fetched;
    word_t out;
    logic miso_oe;
    logic adv;
    logic wr_pend;
    logic [WR_W-1:0] wr_word;
  } state_t;

  state_t s;
  state_t next_s;
  logic rise;
  logic fall;
  logic buf_ready;
  logic [WR_W-1:0] buf_data;

  function automatic logic is_burst_addr(input addr_t a);
    is_burst_addr = (a == ADDR_CARDIAC_BURST) || (a == ADDR_IMPEDANCE_BURST);
  endfunction

  function automatic logic moves_state(input addr_t a);
    moves_state = (a == ADDR_STATUS) || is_burst_addr(a) ||
                  (a == ADDR_CARDIAC_SINGLE) || (a == ADDR_IMPEDANCE_SINGLE);
  endfunction

  // edges seen on the second synchroniser stage against a third copy
  assign rise = s.sclk_s2 & ~s.sclk_d;
  assign fall = ~s.sclk_s2 & s.sclk_d;

  assign MISO = s.out[DATA_W-1];
  assign MISO_OE = s.miso_oe;
  assign RD_REQ = s.rd_req;
  assign RD_ADDR = s.addr;
  assign ADVANCE = s.adv;
  assign ADVANCE_ADDR = s.addr;
  assign WR_ADDR = buf_data[WR_W-1:DATA_W];
  assign WR_DATA = buf_data[DATA_W-1:0];

  always_comb
  begin
    count_t cnt_now;
    cnt_now = EDGE_IDLE;
    next_s = s;
    next_s.cs_s1 = CHIP_SELECT_N;
    next_s.cs_s2 = s.cs_s1;
    next_s.sclk_s1 = SCLK;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_d = s.sclk_s2;
    next_s.mosi_s1 = MOSI;
    next_s.mosi_s2 = s.mosi_s1;
    next_s.rd_req = 1'b0;
    next_s.adv = 1'b0;
    next_s.capture = s.rd_req;
    // read data is taken one cycle after the request, well before the next fall
    if (s.capture)
    begin
      next_s.fetched = RD_DATA;
      next_s.load_pend = 1'b1;
    end
    if (s.wr_pend && buf_ready)
    begin
      next_s.wr_pend = 1'b0;
    end
    if (s.cs_s2)
    begin
      // deselect: no write is queued before edge 32, so nothing executes
      next_s.cnt = EDGE_IDLE;
      next_s.done = 1'b0;
      next_s.is_read = 1'b0;
      next_s.is_burst = 1'b0;
      next_s.load_pend = 1'b0;
      next_s.capture = 1'b0;
      next_s.out = WORD_ZERO;
      next_s.miso_oe = 1'b0;
    end
    else
    begin
      next_s.miso_oe = 1'b1;
      // only rising edges are counted, so both clock idle levels work
      if (rise && !s.done)
      begin
        next_s.shreg = {s.shreg[DATA_W-3:0], s.mosi_s2};
        cnt_now = (s.cnt == EDGE_LAST) ? EDGE_WRAP : s.cnt + 6'h01;
        next_s.cnt = cnt_now;
        if (cnt_now == EDGE_CMD && s.cnt != EDGE_LAST)
        begin
          next_s.addr = s.shreg[ADDR_W-1:0];
          next_s.is_read = (s.mosi_s2 == RW_READ);
          next_s.is_burst = is_burst_addr(s.shreg[ADDR_W-1:0]);
          next_s.rd_req = (s.mosi_s2 == RW_READ);
        end
        if (cnt_now == EDGE_ADVANCE && s.is_read && moves_state(s.addr))
        begin
          next_s.adv = 1'b1;
        end
        if (cnt_now == EDGE_LAST)
        begin
          if (!s.is_read)
          begin
            // one register per frame; later bits are dropped
            next_s.wr_pend = 1'b1;
            next_s.wr_word = {s.addr, s.shreg[DATA_W-2:0], s.mosi_s2};
            next_s.done = 1'b1;
          end
          else if (s.is_burst && FIFO_VALID)
          begin
            next_s.rd_req = 1'b1;
          end
          else
          begin
            next_s.done = 1'b1;
          end
        end
      end
      if (fall)
      begin
        if (s.load_pend)
        begin
          next_s.out = s.fetched;
          next_s.load_pend = 1'b0;
        end
        else
        begin
          // zero fill means excess clocks read back zeros
          next_s.out = {s.out[DATA_W-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s <= '0;
      s.cs_s1 <= 1'b1;
      s.cs_s2 <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // writes queue here so a register file busy for up to three writes loses no word
  two_entry_buffer #(
    .WIDTH(WR_W),
    .DEPTH(BUF_DEPTH)
  ) u_write_buffer (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(s.wr_pend),
    .in_ready(buf_ready),
    .in_data(s.wr_word),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(buf_data)
  );
endmodule

// file: src/spi_port_pkg.sv
// constants, types and field layout of the serial register port
// assumes one system clock; the serial clock is sampled, never used as a clock
//
// Overview of operation
// - serial input bits captured on clock rising edges
// - each access is 32 clocks in one select
// - command byte: seven address bits, read flag
// - clock modes 0/0 and 1/1 both accepted
// - write executes on 32nd rising edge
// - bits after 32nd edge of write ignored
// - early deselect cancels a write; a status or fifo read past edge 30 still advances
// - read fetch at 8th edge, MSB next fall
// - normal read returns zeros after 32 edges
// - status or fifo read advances at edge 30
// - burst fifo reads use their own addresses
// - burst: next word MSB after 32nd edge
// - burst advance at edge 30 plus 24n
// - burst continues while fifo holds data
// - no burst write; one register per frame
// - all registers readable by single frame read
package spi_port_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 24;
  localparam int CNT_W = 6;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [CNT_W-1:0] count_t;

  // rising edge numbers inside a frame
  localparam count_t EDGE_CMD = 6'h08;
  localparam count_t EDGE_ADVANCE = 6'h1E;
  localparam count_t EDGE_LAST = 6'h20;
  // edge 33 of a burst lines up with edge 9 of the first word
  localparam count_t EDGE_WRAP = 6'h09;
  localparam count_t EDGE_IDLE = 6'h00;

  // value of the flag bit that follows the address
  localparam logic RW_READ = 1'b1;

  // addresses whose read moves interrupt state or a fifo pointer
  localparam addr_t ADDR_STATUS = 7'h01;
  localparam addr_t ADDR_CARDIAC_BURST = 7'h20;
  localparam addr_t ADDR_CARDIAC_SINGLE = 7'h21;
  localparam addr_t ADDR_IMPEDANCE_BURST = 7'h22;
  localparam addr_t ADDR_IMPEDANCE_SINGLE = 7'h23;

  localparam int BUF_DEPTH = 2;
  localparam word_t WORD_ZERO = 24'h000000;
endpackage

// file: src/two_entry_buffer.sv
// small first-in first-out buffer with valid and ready on both sides
// assumes both sides on the same clock; synchronous active-low reset
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] count;
  } state_t;

  state_t s;
  state_t next_s;
  logic push;
  logic pop;

  assign in_ready = (s.count != FULL);
  assign out_valid = (s.count != '0);
  assign out_data = s.mem[s.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (pop)
    begin
      next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    // a stalled drain keeps the count up, so in_ready drops and the source waits
    if (push && !pop)
    begin
      next_s.count = s.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule

// file: bench/spi_port_monitor.sv
// checker of the serial port's user-side and enable outputs
// assumes a bind to serial_reg_port and a host clocking at 8 CLK a bit
`timescale 1ns/10ps
module spi_port_monitor
  import spi_port_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CHIP_SELECT_N,
  input wire logic MISO_OE,
  input wire logic RD_REQ,
  input wire spi_port_pkg::addr_t RD_ADDR,
  input wire logic ADVANCE,
  input wire spi_port_pkg::addr_t ADVANCE_ADDR,
  input wire logic WR_VALID,
  input wire logic WR_READY,
  input wire spi_port_pkg::addr_t WR_ADDR,
  input wire spi_port_pkg::word_t WR_DATA
);
  // reads of status and of the fifo addresses move state
  wire logic moves = RD_ADDR == ADDR_STATUS || RD_ADDR[6:2] == 5'h08;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_oe_off: assert property (CHIP_SELECT_N [*4] |-> !MISO_OE)
    else $error("output enabled while deselected");
  a_oe_on: assert property (!CHIP_SELECT_N [*4] |-> MISO_OE)
    else $error("output off while selected");
  a_req_pulse: assert property (RD_REQ |=> !RD_REQ)
    else $error("fetch request longer than a cycle");
  a_adv_pulse: assert property (ADVANCE |=> !ADVANCE)
    else $error("advance longer than a cycle");
  a_adv_addr: assert property (ADVANCE |-> moves && ADVANCE_ADDR == RD_ADDR)
    else $error("advance for an address that moves nothing");
  a_in_frame: assert property ((RD_REQ || ADVANCE) |-> MISO_OE)
    else $error("fetch or advance outside a frame");
  a_wr_hold: assert property (WR_VALID && !WR_READY |=>
    WR_VALID && $stable({WR_ADDR, WR_DATA}))
    else $error("stalled write word changed or lost");
  // 22 serial rises from fetch to advance, one serial bit (8 CLK) either way
  a_fetch_pop: assert property (RD_REQ && moves |-> ##[168:184] ADVANCE)
    else $error("advance not 22 serial clocks after fetch");
  c_burst: cover property (RD_REQ && RD_ADDR == ADDR_CARDIAC_BURST);
  c_pop: cover property (ADVANCE);
  c_stall: cover property (WR_VALID && !WR_READY [*4]);
  c_wr: cover property (WR_VALID && WR_READY);
endmodule

// file: bench/spi_host_model.sv
// host model: master of the serial link, 400 ns bit period
// assumes the bench resolves the data-out wire and calls frame
`timescale 1ns/10ps
module spi_host_model
  import spi_port_pkg::*;
(
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // pol picks mode 0/0 or 1/1; stop > 0 deselects after that many rises
  task automatic frame(input logic [7:0] cmd, input word_t wd, input int words,
    input logic pol, input int stop, output word_t rx[3]);
    // a change of idle level settles before select drops, so it is never counted
    sclk = pol;
    #210 cs_n = 1'b0;
    #200;
    for (int i = 0; i < 8 + 24 * words && (stop == 0 || i < stop); i++)
    begin
      sclk = 1'b0;
      mosi = i < 8 ? cmd[7 - i] : wd[23 - (i - 8) % 24];
      #200 sclk = 1'b1;
      // sampled late in the high phase: the port answers within 3 CLK of the fall
      #190 if (i >= 8) rx[(i - 8) / 24][23 - (i - 8) % 24] = miso;
      #10;
    end
    sclk = pol;
    mosi = ~mosi;
    #200 cs_n = 1'b1;
    #400;
  endtask
endmodule

// file: bench/tb.sv
// bench: host model on the link, register file and one fifo on the user side
// assumes the port, its package, the host model and the monitor
`timescale 1ns/10ps
module tb;
  import spi_port_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, WR_READY = 1'b0, stall = 1'b0;
  logic SCLK, CHIP_SELECT_N, MOSI, MISO, MISO_OE, RD_REQ, ADVANCE, WR_VALID;
  addr_t RD_ADDR, ADVANCE_ADDR, WR_ADDR;
  word_t RD_DATA, WR_DATA, regs [128], fifo [4], rx [3], d [4];
  logic [30:0] eq [$];
  int failures = 0, total_checks = 0, rp = 0, base = 0, fn = 0, adv = 0, a;
  wire logic miso_w = MISO_OE ? MISO : ~MISO;
  wire logic is_f = RD_ADDR[6:2] == 5'h08;
  wire logic FIFO_VALID = rp - base < fn;
  assign RD_DATA = is_f ? fifo[2'(rp - base)] : regs[RD_ADDR];
  always #25 CLK = ~CLK;
  serial_reg_port dut_u (.CLK, .RST_N, .SCLK, .CHIP_SELECT_N, .MOSI, .MISO, .MISO_OE,
    .RD_REQ, .RD_ADDR, .RD_DATA, .FIFO_VALID, .ADVANCE, .ADVANCE_ADDR, .WR_VALID,
    .WR_READY, .WR_ADDR, .WR_DATA);
  spi_host_model host_u (.sclk(SCLK), .cs_n(CHIP_SELECT_N), .mosi(MOSI), .miso(miso_w));
  task automatic chk(input logic [30:0] got, input logic [30:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input addr_t ad, input word_t dt, input int words);
    eq.push_back({ad, dt});
    host_u.frame({ad, 1'b0}, dt, words, 1'($urandom), 0, rx);
  endtask
  task automatic rd(input addr_t ad, input int words);
    host_u.frame({ad, RW_READ}, 24'($urandom), words, 1'($urandom), 0, rx);
  endtask
  // user side: a random ready, so the write buffer sees stalls
  always @(posedge CLK)
  begin
    WR_READY <= !stall && 1'($urandom);
    if (ADVANCE)
      adv <= adv + 1;
    if (ADVANCE && ADVANCE_ADDR[6:2] == 5'h08)
      rp <= rp + 1;
    if (WR_VALID && WR_READY)
    begin
      regs[WR_ADDR] <= WR_DATA;
      chk({WR_ADDR, WR_DATA}, eq.size() ? eq.pop_front() : 31'h7FFFFFFF);
    end
  end
  initial
  begin
    #1000000;
    failures++;
    finish_test();
  end
  initial
  begin
    void'($urandom(10));
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    // the last write carries a second word that must be dropped
    for (int i = 0; i < 4; i++)
    begin
      d[i] = 24'($urandom);
      wr(7'h10 + 7'(i), d[i], 1 + i / 3);
    end
    host_u.frame({7'h10, 1'b0}, 24'hFFFFFF, 1, 1'b0, 31, rx);
    repeat (20) @(posedge CLK);
    chk(31'(eq.size()), 31'h0);
    for (int i = 0; i < 4; i++)
    begin
      rd(7'h10 + 7'(i), 2);
      chk(rx[0], d[i]);
      chk(rx[1], 0);
    end
    // three writes behind a stalled receiver all come out in order
    stall <= 1'b1;
    for (int i = 0; i < 3; i++)
      wr(7'h14 + 7'(i), 24'($urandom), 1);
    chk(WR_VALID, 1'b1);
    stall <= 1'b0;
    repeat (40) @(posedge CLK);
    chk(31'(eq.size()), 31'h0);
    for (int k = 3; k > 1; k--)
    begin
      for (int i = 0; i < 4; i++)
        fifo[i] = 24'($urandom);
      base = rp;
      fn = k;
      rd(ADDR_CARDIAC_BURST, 3);
      for (int i = 0; i < 3; i++)
        chk(rx[i], i < k ? fifo[i] : 24'h000000);
      chk(31'(rp - base), 31'(k));
    end
    fn = 3;
    rd(ADDR_IMPEDANCE_SINGLE, 1);
    chk(rx[0], fifo[2]);
    chk(31'(rp - base), 31'h3);
    a = adv;
    rd(ADDR_STATUS, 1);
    rd(7'h11, 1);
    chk(adv, a + 1);
    finish_test();
  end
endmodule
bind serial_reg_port spi_port_monitor mon_u (.CLK, .RST_N, .CHIP_SELECT_N, .MISO_OE,
  .RD_REQ, .RD_ADDR, .ADVANCE, .ADVANCE_ADDR, .WR_VALID, .WR_READY, .WR_ADDR, .WR_DATA);
